// >>> src/line_sequence_interval_sag_monitor_defs.svh
// register map, field positions and reset values of the line monitor
`ifndef LINE_SEQUENCE_INTERVAL_SAG_MONITOR_DEFS_SVH
`define LINE_SEQUENCE_INTERVAL_SAG_MONITOR_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_EVENT_FLAGS 16'he503
`define IDX_SAG_THRESHOLD 16'he509
`define IDX_EVENT_ENABLES 16'he50b
`define IDX_PER_PHASE_FLAGS 16'he600
`define IDX_INTERVAL_0 16'he601
`define IDX_INTERVAL_1 16'he602
`define IDX_INTERVAL_2 16'he603
`define IDX_COMPUTATION_SETUP 16'he60e
`define IDX_GENERAL_SETUP 16'he618
`define IDX_ACCUMULATION_SETUP 16'he701
`define IDX_SAG_HALF_CYCLES 16'he704
`define IDX_PERIOD_A 16'he905
`define IDX_PERIOD_B 16'he906
`define IDX_PERIOD_C 16'he907

`define BIT_SAG 16
`define BIT_ORDER_FAULT 19
`define FLAGS_IMPL 32'h00090000
`define POS_INTERVAL_SELECT 9
`define POS_ROUTE_A 8
`define POS_WIRING_SELECT 4
`define POS_SAG_STYLE 6
`define POS_SAG_STATE 12

`define RST_GENERAL_SETUP 16'h2400
`define COUNT_MAX 16'hffff
`define TICK_HZ 256000
`define PCLK_HZ 100000000

`endif

// >>> src/line_sequence_interval_sag_monitor_pkg.sv
// types shared by the line monitor
package line_sequence_interval_sag_monitor_pkg;

    typedef enum logic [1:0] {
        PH_A,
        PH_B,
        PH_C,
        PH_NONE
    } phase_e;

    typedef logic [15:0] count_t;

    typedef struct packed {
        logic [23:0] sag_threshold;
        logic [15:0] computation_setup;
        logic [15:0] general_setup;
        logic [7:0] accumulation_setup;
        logic [7:0] sag_half_cycles;
        logic [31:0] event_flags;
        logic [31:0] event_enables;
        phase_e prev;
        phase_e prev2;
        logic order_bad;
        logic [2:0] irun;
        logic [2:0][15:0] icnt;
        logic [2:0][15:0] ires;
        logic [2:0][15:0] pcnt;
        logic [2:0][15:0] pres;
        logic [7:0] half_cnt;
        logic [2:0] low_all;
        logic [2:0] high_all;
        logic [2:0] sag_state;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq_n;
    } state_s;

endpackage

// >>> src/line_sequence_interval_sag_monitor.sv
// line phase order, interval, period and sag monitor with apb registers
`timescale 1ns/100ps
`include "line_sequence_interval_sag_monitor_defs.svh"

module line_sequence_interval_sag_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_tick,
    input wire logic [2:0] volt_rise,
    input wire logic [2:0] curr_rise,
    input wire logic [2:0] volt_small,
    input wire logic half_cycle,
    input wire logic [23:0] volt_a,
    input wire logic [23:0] volt_b,
    input wire logic [23:0] volt_c,
    output logic event_irq_n
);

    line_sequence_interval_sag_monitor_pkg::state_s s_q;
    line_sequence_interval_sag_monitor_pkg::state_s s_d;

    logic [2:0] vr;
    logic [2:0][23:0] vin;
    logic [2:0][23:0] vsel;
    logic [2:0] stt;
    logic [2:0] stp;
    logic [2:0] below;
    logic [2:0] lo_now;
    logic [2:0] hi_now;
    logic access;
    logic done;
    logic [15:0] idx;
    logic period_end;
    logic set_order;
    logic set_sag;
    logic wr_flags;
    logic wr_cycles;

    function automatic logic [1:0] route_src(input logic [1:0] sel, input logic [1:0] own);
        route_src = (sel == 2'h3) ? own : sel;
    endfunction

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == `COUNT_MAX) ? v : v + 16'h0001;
    endfunction

    function automatic logic [23:0] abs24(input logic [23:0] v);
        abs24 = v[23] ? (~v + 24'h000001) : v;
    endfunction

    function automatic line_sequence_interval_sag_monitor_pkg::phase_e
        wrong_prev(input line_sequence_interval_sag_monitor_pkg::phase_e p);
        case (p)
            line_sequence_interval_sag_monitor_pkg::PH_A: wrong_prev = line_sequence_interval_sag_monitor_pkg::PH_B;
            line_sequence_interval_sag_monitor_pkg::PH_B: wrong_prev = line_sequence_interval_sag_monitor_pkg::PH_C;
            line_sequence_interval_sag_monitor_pkg::PH_C: wrong_prev = line_sequence_interval_sag_monitor_pkg::PH_A;
            default: wrong_prev = line_sequence_interval_sag_monitor_pkg::PH_NONE;
        endcase
    endfunction

    assign vin = {volt_c, volt_b, volt_a};
    assign access = psel && penable && !s_q.pready;
    assign done = psel && penable && s_q.pready;
    assign idx = paddr[17:2];
    assign wr_flags = done && pwrite && paddr[1:0] == 2'h0 && idx == `IDX_EVENT_FLAGS;
    assign wr_cycles = done && pwrite && paddr[1:0] == 2'h0 && idx == `IDX_SAG_HALF_CYCLES;

    always_comb begin
        logic [1:0] src;
        logic [1:0] isel;
        line_sequence_interval_sag_monitor_pkg::phase_e p;
        logic hit;
        logic [31:0] rd;
        src = 2'h0;
        isel = s_q.computation_setup[`POS_INTERVAL_SELECT +: 2];
        p = line_sequence_interval_sag_monitor_pkg::PH_NONE;
        hit = 1'b1;
        rd = 32'h00000000;
        s_d = s_q;
        set_order = 1'b0;
        set_sag = 1'b0;
        // routing of each phase voltage onto a datapath; quiet inputs never cross
        for (int i = 0; i < 3; i++) begin
            src = route_src(s_q.general_setup[`POS_ROUTE_A + 2 * i +: 2], 2'(i));
            vr[i] = volt_rise[src] && !volt_small[src];
            vsel[i] = vin[src];
        end
        // phase order: rising voltage crossings, lowest phase wins on a tie
        if (vr[0]) begin
            p = line_sequence_interval_sag_monitor_pkg::PH_A;
        end else if (vr[1]) begin
            p = line_sequence_interval_sag_monitor_pkg::PH_B;
        end else if (vr[2]) begin
            p = line_sequence_interval_sag_monitor_pkg::PH_C;
        end
        if (p != line_sequence_interval_sag_monitor_pkg::PH_NONE) begin
            s_d.prev = p;
            s_d.prev2 = s_q.prev;
            if (s_q.prev != wrong_prev(p)) begin
                s_d.order_bad = 1'b0;
            end else if (p == line_sequence_interval_sag_monitor_pkg::PH_B
                    && s_q.prev2 == line_sequence_interval_sag_monitor_pkg::PH_A) begin
                s_d.order_bad = 1'b1;
                set_order = 1'b1;
            end else if (s_q.order_bad) begin
                set_order = 1'b1;
            end
        end
        // interval pairs
        case (isel)
            2'h1: begin
                stt = {vr[0], vr[1], vr[0]};
                stp = {vr[1], vr[2], vr[2]};
            end
            2'h2: begin
                stt = {curr_rise[0], curr_rise[1], curr_rise[0]};
                stp = {curr_rise[1], curr_rise[2], curr_rise[2]};
            end
            default: begin
                stt = vr;
                stp = curr_rise;
            end
        endcase
        for (int i = 0; i < 3; i++) begin
            if (stp[i] && s_q.irun[i]) begin
                s_d.ires[i] = s_q.icnt[i];
                s_d.irun[i] = 1'b0;
            end
            if (stt[i]) begin
                s_d.irun[i] = 1'b1;
                s_d.icnt[i] = 16'h0000;
            end else if (s_q.irun[i] && sample_tick) begin
                s_d.icnt[i] = sat_inc(s_q.icnt[i]);
            end
            if (vr[i]) begin
                s_d.pres[i] = s_q.pcnt[i];
                s_d.pcnt[i] = 16'h0000;
            end else if (sample_tick) begin
                s_d.pcnt[i] = sat_inc(s_q.pcnt[i]);
            end
        end
        // sag: each tick narrows whether a phase stayed below or above
        for (int i = 0; i < 3; i++) begin
            below[i] = abs24(vsel[i]) < s_q.sag_threshold;
            lo_now[i] = s_q.low_all[i] && !(sample_tick && !below[i]);
            hi_now[i] = s_q.high_all[i] && !(sample_tick && below[i]);
        end
        s_d.low_all = lo_now;
        s_d.high_all = hi_now;
        period_end = half_cycle && ({1'b0, s_q.half_cnt} + 9'h001 == {1'b0, s_q.sag_half_cycles});
        if (period_end) begin
            s_d.half_cnt = 8'h00;
            s_d.low_all = 3'h7;
            s_d.high_all = 3'h7;
            for (int i = 0; i < 3; i++) begin
                if (lo_now[i]) begin
                    s_d.sag_state[i] = 1'b1;
                end else if (hi_now[i]) begin
                    s_d.sag_state[i] = 1'b0;
                end
            end
            if (s_q.accumulation_setup[`POS_SAG_STYLE]) begin
                set_sag = |(s_q.sag_state & hi_now);
            end else begin
                set_sag = |lo_now;
            end
        end else if (half_cycle) begin
            s_d.half_cnt = s_q.half_cnt + 8'h01;
        end
        if (wr_cycles) begin
            s_d.half_cnt = 8'h00;
            s_d.low_all = 3'h7;
            s_d.high_all = 3'h7;
        end
        // apb read decode, answered one cycle into the access phase
        case (idx)
            `IDX_EVENT_FLAGS: rd = s_q.event_flags;
            `IDX_SAG_THRESHOLD: rd = {8'h00, s_q.sag_threshold};
            `IDX_EVENT_ENABLES: rd = s_q.event_enables;
            `IDX_PER_PHASE_FLAGS: rd = {17'h00000, s_q.sag_state, 12'h000};
            `IDX_INTERVAL_0: rd = {16'h0000, s_q.ires[0]};
            `IDX_INTERVAL_1: rd = {16'h0000, s_q.ires[1]};
            `IDX_INTERVAL_2: rd = {16'h0000, s_q.ires[2]};
            `IDX_COMPUTATION_SETUP: rd = {16'h0000, s_q.computation_setup};
            `IDX_GENERAL_SETUP: rd = {16'h0000, s_q.general_setup};
            `IDX_ACCUMULATION_SETUP: rd = {24'h000000, s_q.accumulation_setup};
            `IDX_SAG_HALF_CYCLES: rd = {24'h000000, s_q.sag_half_cycles};
            `IDX_PERIOD_A: rd = {16'h0000, s_q.pres[0]};
            `IDX_PERIOD_B: rd = {16'h0000, s_q.pres[1]};
            `IDX_PERIOD_C: rd = {16'h0000, s_q.pres[2]};
            default: hit = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end
        s_d.pready = access;
        s_d.pslverr = access && !hit;
        if (access) begin
            s_d.prdata = (hit && !pwrite) ? rd : 32'h00000000;
        end
        if (done && pwrite && hit) begin
            case (idx)
                `IDX_SAG_THRESHOLD: s_d.sag_threshold = pwdata[23:0];
                `IDX_EVENT_ENABLES: s_d.event_enables = pwdata;
                `IDX_COMPUTATION_SETUP: s_d.computation_setup = pwdata[15:0];
                `IDX_GENERAL_SETUP: s_d.general_setup = pwdata[15:0];
                `IDX_ACCUMULATION_SETUP: s_d.accumulation_setup = pwdata[7:0];
                `IDX_SAG_HALF_CYCLES: s_d.sag_half_cycles = pwdata[7:0];
                default: s_d.sag_threshold = s_q.sag_threshold;
            endcase
        end
        // write-one-to-clear; a set in the same cycle wins
        s_d.event_flags = s_q.event_flags & ~(wr_flags ? (pwdata & `FLAGS_IMPL) : 32'h0);
        s_d.event_flags[`BIT_ORDER_FAULT] = s_d.event_flags[`BIT_ORDER_FAULT] || set_order;
        s_d.event_flags[`BIT_SAG] = s_d.event_flags[`BIT_SAG] || set_sag;
        s_d.irq_n = !(|(s_d.event_flags & s_d.event_enables));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.general_setup <= `RST_GENERAL_SETUP;
            s_q.prev <= line_sequence_interval_sag_monitor_pkg::PH_NONE;
            s_q.prev2 <= line_sequence_interval_sag_monitor_pkg::PH_NONE;
            s_q.low_all <= 3'h7;
            s_q.high_all <= 3'h7;
            s_q.irq_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign event_irq_n = s_q.irq_n;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    order_irq_a: assert property (
        $rose(s_q.event_flags[`BIT_ORDER_FAULT]) && s_q.event_enables[`BIT_ORDER_FAULT]
        |-> !event_irq_n)
        else $error("order fault enabled but interrupt high");
    order_cause_a: assert property (
        $rose(s_q.event_flags[`BIT_ORDER_FAULT]) |-> $past(|vr))
        else $error("order fault set without a rising voltage crossing");
    order_clear_a: assert property (
        wr_flags && pwdata[`BIT_ORDER_FAULT] && !set_order
        |=> !s_q.event_flags[`BIT_ORDER_FAULT])
        else $error("order fault not cleared by write of one");
    sag_clear_a: assert property (
        wr_flags && pwdata[`BIT_SAG] && !set_sag && !period_end
        |=> !s_q.event_flags[`BIT_SAG] ##0 s_q.sag_state == $past(s_q.sag_state))
        else $error("sag clear failed or disturbed sag state");
    interval_store_a: assert property (
        stp[0] && s_q.irun[0] |=> s_q.ires[0] == $past(s_q.icnt[0]))
        else $error("interval result not captured at stop");
    period_store_a: assert property (
        vr[1] |=> s_q.pres[1] == $past(s_q.pcnt[1]) ##0 s_q.pcnt[1] == 16'h0000)
        else $error("period not captured at crossing");
    count_sat_a: assert property (
        s_q.pcnt[2] == 16'hffff && !vr[2] |=> s_q.pcnt[2] == 16'hffff)
        else $error("period counter wrapped");
    half_restart_a: assert property (
        wr_cycles |=> s_q.half_cnt == 8'h00 ##1 s_q.half_cnt <= 8'h01)
        else $error("half cycle counter not restarted");
    apb_answer_a: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not one wait state");
    sag_state_a: assert property (
        !period_end |=> s_q.sag_state == $past(s_q.sag_state))
        else $error("sag state changed outside a period end");

    order_seen_c: cover property (set_order ##[1:1000] set_order);
    sag_style1_c: cover property (s_q.accumulation_setup[`POS_SAG_STYLE] && set_sag);
    interval_mode1_c: cover property (
        s_q.computation_setup[`POS_INTERVAL_SELECT +: 2] == 2'h1 && stp[0] && s_q.irun[0]);

endmodule

// >>> bench/line_sequence_interval_sag_monitor_test.sv
// self-checking apb bench for the line order, interval, period and sag monitor
`timescale 1ns/100ps
`include "line_sequence_interval_sag_monitor_defs.svh"

module line_sequence_interval_sag_monitor_test;
    logic pclk, presetn, psel, penable, pwrite, sample_tick, half_cycle;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, event_irq_n, err;
    logic [2:0] volt_rise, curr_rise, volt_small;
    logic [23:0] volt_a, volt_b, volt_c;
    int failures, check_count;

    line_sequence_interval_sag_monitor line_sequence_interval_sag_monitor_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_tick(sample_tick), .volt_rise(volt_rise), .curr_rise(curr_rise),
        .volt_small(volt_small), .half_cycle(half_cycle), .volt_a(volt_a), .volt_b(volt_b),
        .volt_c(volt_c), .event_irq_n(event_irq_n));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", failures, check_count);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask

    task automatic ev(input logic [2:0] v, input logic [2:0] c);
        @(posedge pclk);
        volt_rise <= v;
        curr_rise <= c;
        @(posedge pclk);
        volt_rise <= 3'h0;
        curr_rise <= 3'h0;
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge pclk);
            sample_tick <= 1'b1;
            @(posedge pclk);
            sample_tick <= 1'b0;
        end
    endtask

    task automatic halfs(input int n);
        repeat (n) begin
            ticks(2);
            @(posedge pclk);
            half_cycle <= 1'b1;
            @(posedge pclk);
            half_cycle <= 1'b0;
        end
    endtask

    task automatic irq(input logic exp);
        @(negedge pclk);
        chk({31'h0, event_irq_n}, {31'h0, exp});
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        failures++;
        conclude();
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, sample_tick, half_cycle} = 5'h00;
        paddr = 18'h00000;
        pwdata = 32'h0;
        {volt_rise, curr_rise, volt_small} = 9'h000;
        volt_a = 24'h000000;
        volt_b = 24'h000000;
        volt_c = 24'h000000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`IDX_GENERAL_SETUP, 32'h00002400);
        rchk(`IDX_EVENT_ENABLES, 32'h0);
        apb(1'b0, 16'h0000, 32'h0);
        chk({31'h0, err}, 32'h1);
        // order A, C, B raises the fault
        apb(1'b1, `IDX_EVENT_ENABLES, 32'h00080000);
        ev(3'h1, 3'h0);
        ev(3'h4, 3'h7);
        ev(3'h2, 3'h0);
        irq(1'b0);
        rchk(`IDX_EVENT_FLAGS, 32'h00080000);
        apb(1'b1, `IDX_EVENT_FLAGS, 32'h00080000);
        irq(1'b1);
        ev(3'h1, 3'h0);
        rchk(`IDX_EVENT_FLAGS, 32'h00080000);
        apb(1'b1, `IDX_EVENT_FLAGS, 32'h0);
        rchk(`IDX_EVENT_FLAGS, 32'h00080000);
        apb(1'b1, `IDX_EVENT_FLAGS, 32'h00080000);
        ev(3'h2, 3'h0);
        ev(3'h4, 3'h0);
        rchk(`IDX_EVENT_FLAGS, 32'h0);
        // interval selections 00, 01, 10 write result 0
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, `IDX_COMPUTATION_SETUP, 32'(s) << `POS_INTERVAL_SELECT);
            ev((s < 2) ? 3'h1 : 3'h0, (s == 2) ? 3'h1 : 3'h0);
            ticks(3 + s);
            ev((s == 1) ? 3'h4 : 3'h0, (s == 0) ? 3'h1 : ((s == 2) ? 3'h4 : 3'h0));
            rchk(`IDX_INTERVAL_0, 32'(3 + s));
        end
        ev(3'h2, 3'h0);
        ticks(7);
        ev(3'h2, 3'h0);
        rchk(`IDX_PERIOD_B, 32'h7);
        // a quiet phase b gives no crossing, so its period is not updated
        volt_small <= 3'h2;
        ticks(3);
        ev(3'h2, 3'h0);
        rchk(`IDX_PERIOD_B, 32'h7);
        volt_small <= 3'h0;
        // route phase a voltage into datapath b
        apb(1'b1, `IDX_GENERAL_SETUP, 32'h00002000);
        ev(3'h1, 3'h0);
        ticks(5);
        ev(3'h1, 3'h0);
        rchk(`IDX_PERIOD_B, 32'h5);
        apb(1'b1, `IDX_GENERAL_SETUP, 32'h00002400);
        // sag style 0, phase a low
        apb(1'b1, `IDX_EVENT_FLAGS, 32'h00090000);
        apb(1'b1, `IDX_EVENT_ENABLES, 32'h00010000);
        apb(1'b1, `IDX_SAG_THRESHOLD, 32'h00000100);
        volt_a <= 24'hffffc0;
        volt_b <= 24'h001000;
        volt_c <= 24'h001000;
        apb(1'b1, `IDX_SAG_HALF_CYCLES, 32'h2);
        halfs(2);
        irq(1'b0);
        rchk(`IDX_EVENT_FLAGS, 32'h00010000);
        rchk(`IDX_PER_PHASE_FLAGS, 32'h00001000);
        apb(1'b1, `IDX_EVENT_FLAGS, 32'h00010000);
        irq(1'b1);
        rchk(`IDX_PER_PHASE_FLAGS, 32'h00001000);
        // style 1: quiet while low, flag on recovery
        apb(1'b1, `IDX_ACCUMULATION_SETUP, 32'h40);
        halfs(2);
        rchk(`IDX_EVENT_FLAGS, 32'h0);
        volt_a <= 24'h002000;
        halfs(2);
        rchk(`IDX_EVENT_FLAGS, 32'h00010000);
        rchk(`IDX_PER_PHASE_FLAGS, 32'h0);
        conclude();
    end
endmodule
